// File: common/tdo_pkg.sv
// Constants, register map and types for the touch detect output logic.
// Assumes a 40 MHz hclk and a 14-bit acquisition result per burst.
package tdo_pkg;

  localparam int unsigned CLK_HZ  = 40000000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1000000;

  // Times in their own units, then cycle counts derived from them.
  localparam int unsigned T_BURST_US      = 95000;
  localparam int unsigned T_CONFIRM_US    = 2000;
  localparam int unsigned T_HEALTH_US     = 350;
  localparam int unsigned T_PULSE_US      = 95000;
  localparam int unsigned T_TONE_US       = 95000;
  localparam int unsigned T_TONE_HALF_US  = 125;
  localparam longint unsigned T_TIMEOUT_SHORT_S = 10;
  localparam longint unsigned T_TIMEOUT_LONG_S  = 60;

  localparam logic [31:0] BURST_CYC     = 32'(T_BURST_US * CLK_MHZ);
  localparam logic [31:0] CONFIRM_CYC   = 32'(T_CONFIRM_US * CLK_MHZ);
  localparam logic [31:0] HEALTH_CYC    = 32'(T_HEALTH_US * CLK_MHZ);
  localparam logic [31:0] PULSE_CYC     = 32'(T_PULSE_US * CLK_MHZ);
  localparam logic [31:0] TONE_CYC      = 32'(T_TONE_US * CLK_MHZ);
  localparam logic [31:0] TONE_HALF_CYC = 32'(T_TONE_HALF_US * CLK_MHZ);
  localparam logic [31:0] TMO_SHORT_CYC = 32'(T_TIMEOUT_SHORT_S * 64'(CLK_HZ));
  localparam logic [31:0] TMO_LONG_CYC  = 32'(T_TIMEOUT_LONG_S * 64'(CLK_HZ));

  // Detection integrator.
  localparam logic [2:0] INTEG_FINAL = 3'h4;

  // Threshold offsets per gain; hysteresis is 17 percent of each.
  localparam logic [13:0] THR_HIGH  = 14'h000a;
  localparam logic [13:0] THR_MED   = 14'h0014;
  localparam logic [13:0] THR_LOW   = 14'h0028;
  localparam logic [13:0] HYST_HIGH = 14'((32'(THR_HIGH) * 17) / 100);
  localparam logic [13:0] HYST_MED  = 14'((32'(THR_MED) * 17) / 100);
  localparam logic [13:0] HYST_LOW  = 14'((32'(THR_LOW) * 17) / 100);

  // Gain strap codes.
  localparam logic [1:0] GAIN_OPEN  = 2'h0;
  localparam logic [1:0] GAIN_SNS_A = 2'h1;

  // Register byte offsets.
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_REF    = 4'h4;
  localparam logic [3:0] ADDR_SIGNAL = 4'h8;
  localparam logic [3:0] ADDR_DRIFT  = 4'hc;

  // Drift register fields and reset values.
  localparam int unsigned DRIFT_RISE_LSB = 0;
  localparam int unsigned DRIFT_FALL_LSB = 8;
  localparam logic [7:0] DRIFT_RISE_RST = 8'h01;
  localparam logic [7:0] DRIFT_FALL_RST = 8'h08;

  // Status register fields.
  localparam int unsigned ST_DETECT_BIT = 0;
  localparam int unsigned ST_OUT_BIT    = 1;
  localparam int unsigned ST_RECAL_BIT  = 2;
  localparam int unsigned ST_TONE_BIT   = 3;
  localparam int unsigned ST_INTEG_LSB  = 4;
  localparam int unsigned ST_MODE_LSB   = 8;
  localparam int unsigned ST_GAIN_LSB   = 12;

  typedef enum logic [1:0] {MODE_DC10, MODE_DC60, MODE_TOGGLE, MODE_PULSE} tdo_mode_t;
  typedef enum logic [1:0] {PH_WAIT, PH_HEALTH, PH_ACQ} tdo_phase_t;

endpackage

// File: design/tdo_core.sv
// Touch detect output logic: burst sequencing, drift-compensated reference,
// detection integrator, obstruction timeout, output modes and AHB-Lite registers.
// Assumes hresetn is the power-up reset and the acquisition converter answers
// each acq_start pulse with one acq_done pulse carrying acq_result.
// Behaviour
// - Gain strap picks one of three threshold offsets.
// - Reference slews toward signal when not detecting.
// - Reference frozen while a detection is in effect.
// - Reference falls faster than it rises.
// - Threshold and hysteresis ride on the reference.
// - Release below threshold by 17 percent hysteresis.
// - Detection longer than timeout forces full recalibration.
// - Four successive detecting bursts activate the output.
// - Non-detecting burst clears integrator at once.
// - Bursts 95 ms apart, confirmations 2 ms apart.
// - Recalibration at power-up and after a timeout, no input.
// - Straps sampled only at power-up.
// - Mode straps select DC, toggle or pulse and timeout.
// - DC output follows detection, cleared by timeout.
// - Toggle inverts per detection, timeout keeps state.
// - Pulse mode emits one 95 ms pulse.
// - Pulse mode timeout fixed at 10 seconds.
// - No piezo tone in pulse mode.
// - Output tri-stated 350 us before every burst.
// - Tone of 95 ms across sense terminals.
// - Results from 14-bit converter under burst control.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module tdo_core #(
  parameter logic [31:0] BURST_CYC     = tdo_pkg::BURST_CYC,
  parameter logic [31:0] CONFIRM_CYC   = tdo_pkg::CONFIRM_CYC,
  parameter logic [31:0] HEALTH_CYC    = tdo_pkg::HEALTH_CYC,
  parameter logic [31:0] PULSE_CYC     = tdo_pkg::PULSE_CYC,
  parameter logic [31:0] TONE_CYC      = tdo_pkg::TONE_CYC,
  parameter logic [31:0] TONE_HALF_CYC = tdo_pkg::TONE_HALF_CYC,
  parameter logic [31:0] TMO_SHORT_CYC = tdo_pkg::TMO_SHORT_CYC,
  parameter logic [31:0] TMO_LONG_CYC  = tdo_pkg::TMO_LONG_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [1:0]  gain_strap,
  input  wire logic        mode_strap_a,
  input  wire logic        mode_strap_b,
  output logic             acq_start,
  input  wire logic        acq_done,
  input  wire logic [13:0] acq_result,
  output logic             out_o,
  output logic             out_oe,
  output logic             sense_terminal_a,
  output logic             sense_terminal_b,
  output logic             sense_drive_en
);

  typedef struct packed {
    tdo_pkg::tdo_phase_t phase;
    logic [31:0]         cnt;
    logic                straps_done;
    logic [1:0]          gain;
    tdo_pkg::tdo_mode_t  mode;
    logic [13:0]         ref_lvl;
    logic [13:0]         sig;
    logic [2:0]          integ;
    logic                detect;
    logic                recal;
    logic [31:0]         det_cnt;
    logic                out;
    logic                oe;
    logic                start;
    logic [31:0]         pulse_cnt;
    logic [31:0]         tone_cnt;
    logic [31:0]         half_cnt;
    logic                tone_ph;
    logic                ahb_wr;
    logic [3:0]          ahb_addr;
    logic [31:0]         rdata;
    logic [7:0]          drift_rise;
    logic [7:0]          drift_fall;
  } tdo_state_t;

  tdo_state_t  st_r;
  tdo_state_t  st_nxt;
  logic [14:0] thr_lvl;
  logic [14:0] rel_lvl;
  logic        above;
  logic        tone_on;

  function automatic tdo_pkg::tdo_mode_t tdo_decode_mode(input logic a, input logic b);
    if (a && b)
      return tdo_pkg::MODE_DC10;
    else if (a)
      return tdo_pkg::MODE_DC60;
    else if (!b)
      return tdo_pkg::MODE_TOGGLE;
    else
      return tdo_pkg::MODE_PULSE;
  endfunction

  function automatic logic [13:0] tdo_thr(input logic [1:0] g, input logic hyst);
    if (g == tdo_pkg::GAIN_OPEN)
      return hyst ? tdo_pkg::HYST_HIGH : tdo_pkg::THR_HIGH;
    else if (g == tdo_pkg::GAIN_SNS_A)
      return hyst ? tdo_pkg::HYST_MED : tdo_pkg::THR_MED;
    else
      return hyst ? tdo_pkg::HYST_LOW : tdo_pkg::THR_LOW;
  endfunction

  // Threshold and release level are fixed offsets above the moving reference.
  assign thr_lvl = {1'b0, st_r.ref_lvl} + {1'b0, tdo_thr(st_r.gain, 1'b0)};
  assign rel_lvl = thr_lvl - {1'b0, tdo_thr(st_r.gain, 1'b1)};
  assign above   = {1'b0, acq_result} >= thr_lvl;
  assign tone_on = st_r.tone_cnt != 32'h0000_0000;

  always_comb
  begin
    logic [31:0] tmo;
    logic        new_det;
    logic [13:0] diff;
    logic [31:0] rd;
    tmo     = (st_r.mode == tdo_pkg::MODE_DC60) ? TMO_LONG_CYC : TMO_SHORT_CYC;
    new_det = 1'b0;
    diff    = 14'h0000;
    rd      = 32'h0000_0000;
    st_nxt  = st_r;
    st_nxt.start = 1'b0;

    // Straps are caught once after power-up and never again.
    if (!st_r.straps_done)
    begin
      st_nxt.straps_done = 1'b1;
      st_nxt.gain        = gain_strap;
      st_nxt.mode        = tdo_decode_mode(mode_strap_a, mode_strap_b);
    end

    // Burst sequencer: wait, health window, then one conversion.
    unique case (st_r.phase)
      tdo_pkg::PH_WAIT:
      begin
        if (st_r.cnt <= 32'h0000_0001)
        begin
          st_nxt.phase = tdo_pkg::PH_HEALTH;
          st_nxt.cnt   = HEALTH_CYC;
        end
        else
          st_nxt.cnt = st_r.cnt - 32'h0000_0001;
      end
      tdo_pkg::PH_HEALTH:
      begin
        if (st_r.cnt <= 32'h0000_0001)
        begin
          st_nxt.phase = tdo_pkg::PH_ACQ;
          st_nxt.start = 1'b1;
        end
        else
          st_nxt.cnt = st_r.cnt - 32'h0000_0001;
      end
      tdo_pkg::PH_ACQ:
      begin
        if (acq_done)
        begin
          st_nxt.phase = tdo_pkg::PH_WAIT;
          st_nxt.sig   = acq_result;
          if (st_r.recal)
          begin
            // Full recalibration: reference snaps to the present signal.
            st_nxt.ref_lvl = acq_result;
            st_nxt.recal   = 1'b0;
            st_nxt.integ   = 3'h0;
          end
          else if (st_r.detect)
          begin
            if ({1'b0, acq_result} < rel_lvl)
            begin
              st_nxt.detect = 1'b0;
              st_nxt.integ  = 3'h0;
            end
          end
          else if (above)
          begin
            st_nxt.integ = st_r.integ + 3'h1;
            if (st_r.integ + 3'h1 == tdo_pkg::INTEG_FINAL)
            begin
              st_nxt.detect = 1'b1;
              new_det       = 1'b1;
            end
          end
          else
          begin
            st_nxt.integ = 3'h0;
            // Rising drift is slow so an approaching finger is not absorbed.
            if (acq_result > st_r.ref_lvl)
            begin
              diff = acq_result - st_r.ref_lvl;
              st_nxt.ref_lvl = st_r.ref_lvl +
                ((diff > 14'(st_r.drift_rise)) ? 14'(st_r.drift_rise) : diff);
            end
            else
            begin
              diff = st_r.ref_lvl - acq_result;
              st_nxt.ref_lvl = st_r.ref_lvl -
                ((diff > 14'(st_r.drift_fall)) ? 14'(st_r.drift_fall) : diff);
            end
          end
          // Confirmation bursts follow quickly; otherwise the slow cadence.
          if (st_nxt.integ != 3'h0 && !st_nxt.detect)
            st_nxt.cnt = CONFIRM_CYC;
          else
            st_nxt.cnt = BURST_CYC;
        end
      end
    endcase
    st_nxt.oe = st_nxt.phase != tdo_pkg::PH_HEALTH;

    // Obstruction timer runs only while a detection is in effect.
    if (st_r.detect && st_nxt.detect)
    begin
      if (st_r.det_cnt >= tmo - 32'h0000_0001)
      begin
        st_nxt.detect  = 1'b0;
        st_nxt.recal   = 1'b1;
        st_nxt.integ   = 3'h0;
        st_nxt.det_cnt = 32'h0000_0000;
      end
      else
        st_nxt.det_cnt = st_r.det_cnt + 32'h0000_0001;
    end
    else
      st_nxt.det_cnt = 32'h0000_0000;

    // Output modes.
    unique case (st_r.mode)
      tdo_pkg::MODE_DC10, tdo_pkg::MODE_DC60:
        st_nxt.out = st_nxt.detect;
      tdo_pkg::MODE_TOGGLE:
      begin
        if (new_det)
          st_nxt.out = !st_r.out;
      end
      tdo_pkg::MODE_PULSE:
      begin
        if (new_det)
        begin
          st_nxt.out       = 1'b1;
          st_nxt.pulse_cnt = PULSE_CYC;
        end
        else if (st_r.pulse_cnt > 32'h0000_0001)
          st_nxt.pulse_cnt = st_r.pulse_cnt - 32'h0000_0001;
        else
        begin
          st_nxt.pulse_cnt = 32'h0000_0000;
          st_nxt.out       = 1'b0;
        end
      end
    endcase

    // Piezo tone: antiphase square wave across the two sense terminals.
    if (new_det && st_r.mode != tdo_pkg::MODE_PULSE)
    begin
      st_nxt.tone_cnt = TONE_CYC;
      st_nxt.half_cnt = TONE_HALF_CYC;
      st_nxt.tone_ph  = 1'b1;
    end
    else if (tone_on)
    begin
      st_nxt.tone_cnt = st_r.tone_cnt - 32'h0000_0001;
      if (st_r.half_cnt <= 32'h0000_0001)
      begin
        st_nxt.half_cnt = TONE_HALF_CYC;
        st_nxt.tone_ph  = !st_r.tone_ph;
      end
      else
        st_nxt.half_cnt = st_r.half_cnt - 32'h0000_0001;
    end

    // AHB-Lite slave: read data is prepared at the address phase edge.
    st_nxt.ahb_wr = 1'b0;
    if (st_r.ahb_wr && st_r.ahb_addr == tdo_pkg::ADDR_DRIFT)
    begin
      st_nxt.drift_rise = hwdata[tdo_pkg::DRIFT_RISE_LSB +: 8];
      st_nxt.drift_fall = hwdata[tdo_pkg::DRIFT_FALL_LSB +: 8];
    end
    if (hsel && htrans[1] && hready)
    begin
      st_nxt.ahb_wr   = hwrite;
      st_nxt.ahb_addr = haddr[3:0];
      unique case (haddr[3:0])
        tdo_pkg::ADDR_STATUS:
        begin
          rd[tdo_pkg::ST_DETECT_BIT]     = st_r.detect;
          rd[tdo_pkg::ST_OUT_BIT]        = st_r.out;
          rd[tdo_pkg::ST_RECAL_BIT]      = st_r.recal;
          rd[tdo_pkg::ST_TONE_BIT]       = tone_on;
          rd[tdo_pkg::ST_INTEG_LSB +: 3] = st_r.integ;
          rd[tdo_pkg::ST_MODE_LSB +: 2]  = st_r.mode;
          rd[tdo_pkg::ST_GAIN_LSB +: 2]  = st_r.gain;
        end
        tdo_pkg::ADDR_REF:    rd[13:0] = st_r.ref_lvl;
        tdo_pkg::ADDR_SIGNAL: rd[13:0] = st_r.sig;
        tdo_pkg::ADDR_DRIFT:
        begin
          rd[tdo_pkg::DRIFT_RISE_LSB +: 8] = st_r.drift_rise;
          rd[tdo_pkg::DRIFT_FALL_LSB +: 8] = st_r.drift_fall;
        end
        default: rd = 32'h0000_0000;
      endcase
      st_nxt.rdata = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r            <= '0;
      st_r.phase      <= tdo_pkg::PH_WAIT;
      st_r.cnt        <= 32'h0000_0001;
      st_r.mode       <= tdo_pkg::MODE_DC10;
      st_r.recal      <= 1'b1;
      st_r.oe         <= 1'b1;
      st_r.drift_rise <= tdo_pkg::DRIFT_RISE_RST;
      st_r.drift_fall <= tdo_pkg::DRIFT_FALL_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st_r.rdata;
  assign acq_start        = st_r.start;
  assign out_o            = st_r.out;
  assign out_oe           = st_r.oe;
  assign sense_drive_en   = tone_on;
  assign sense_terminal_a = tone_on & st_r.tone_ph;
  assign sense_terminal_b = tone_on & !st_r.tone_ph;

  // A burst must follow a tri-state window, and the output only returns with it.
  AST_HEALTH_BEFORE_BURST: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_r.oe) |-> acq_start && $past(st_r.phase) == tdo_pkg::PH_HEALTH)
    else $error("output re-enabled without a burst start");
  AST_REF_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(st_r.detect) && st_r.detect |-> $stable(st_r.ref_lvl))
    else $error("reference moved during detection");
  AST_FOUR_TO_DETECT: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_r.detect) |-> $past(st_r.integ) == 3'h3 && st_r.integ == 3'h4)
    else $error("detection without four confirming bursts");
  AST_INTEG_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.phase == tdo_pkg::PH_ACQ && acq_done && !above && !st_r.detect
    |=> st_r.integ == 3'h0)
    else $error("integrator not cleared by non-detecting burst");
  AST_DC_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.straps_done && (st_r.mode == tdo_pkg::MODE_DC10 || st_r.mode == tdo_pkg::MODE_DC60)
    |=> out_o == st_r.detect)
    else $error("DC output differs from detection");
  AST_PULSE_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.straps_done && st_r.mode == tdo_pkg::MODE_PULSE |-> !sense_drive_en)
    else $error("tone driven in pulse mode");
  AST_STRAPS_HELD: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(st_r.straps_done) |-> $stable(st_r.mode) && $stable(st_r.gain))
    else $error("strap setting changed after power-up");
  AST_RISE_SLEW: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.ref_lvl > $past(st_r.ref_lvl) && !$past(st_r.recal)
    |-> st_r.ref_lvl - $past(st_r.ref_lvl) <= 14'($past(st_r.drift_rise)))
    else $error("reference rose faster than the rise step");
  AST_TIMEOUT_BOUND: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.detect |->
    st_r.det_cnt < ((st_r.mode == tdo_pkg::MODE_DC60) ? TMO_LONG_CYC : TMO_SHORT_CYC))
    else $error("detection outlived the timeout");
  AST_TOGGLE_FLIP: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.mode == tdo_pkg::MODE_TOGGLE && $rose(st_r.detect) |-> out_o != $past(out_o))
    else $error("toggle output did not invert on detection");

  COV_DETECT: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_r.detect));
  COV_TIMEOUT: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_r.recal));
  COV_TONE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(sense_drive_en));
  COV_DRIFT_WRITE: cover property (@(posedge hclk) disable iff (!hresetn)
    st_r.ahb_wr && st_r.ahb_addr == tdo_pkg::ADDR_DRIFT);

endmodule

// File: tb/tdo_conv_model.sv
// Far-side model: the acquisition converter and a host load on the output line.
// Assumes the bench sets the signal level and the conversion delay of each burst.
`timescale 1ns/1ps
module tdo_conv_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        acq_start,
  input  wire logic [3:0]  dly,
  input  wire logic [13:0] level,
  input  wire logic        out_o,
  input  wire logic        out_oe,
  output logic             acq_done,
  output logic [13:0]      acq_result,
  output logic [15:0]      hb_cnt
);
  logic [3:0] wait_r;
  logic       busy_r;
  logic       pull_r;
  logic       seen_r;
  logic       line;

  // The result is only valid with the done pulse, so it shows garbage otherwise.
  assign acq_result = acq_done ? level : ~level;
  // The load pulls against the driven level, so a tri-state window is always visible.
  assign line = out_oe ? out_o : pull_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_r   <= 1'b0;
      wait_r   <= 4'h0;
      acq_done <= 1'b0;
      pull_r   <= 1'b1;
      seen_r   <= 1'b0;
      hb_cnt   <= 16'h0;
    end
    else
    begin
      acq_done <= 1'b0;
      if (out_oe)
        pull_r <= ~out_o;
      seen_r <= !out_oe && (line != out_o);
      if (!seen_r && !out_oe && (line != out_o))
        hb_cnt <= hb_cnt + 16'h1;
      if (acq_start)
      begin
        busy_r <= 1'b1;
        wait_r <= dly;
      end
      else if (busy_r && wait_r == 4'h0)
      begin
        busy_r   <= 1'b0;
        acq_done <= 1'b1;
      end
      else if (busy_r)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule

// File: tb/tdo_core_bench.sv
// Self-checking bench: one power-up per output mode with touch, drift,
// hysteresis and timeout sequences, plus register access over AHB-Lite.
// Assumes shortened timing parameters and the converter model beside the design.
`timescale 1ns/1ps
module tdo_core_bench;
  localparam logic [31:0] BURST  = 32'hc8;
  localparam logic [31:0] HEALTH = 32'ha;
  localparam logic [31:0] PULSE  = 32'h32;
  localparam logic [31:0] TMS    = 32'h7d0;
  localparam logic [31:0] TML    = 32'h1388;
  localparam logic [31:0] A_ST   = {28'h0, tdo_pkg::ADDR_STATUS};
  localparam logic [31:0] A_REF  = {28'h0, tdo_pkg::ADDR_REF};
  localparam logic [31:0] A_SIG  = {28'h0, tdo_pkg::ADDR_SIGNAL};
  localparam logic [31:0] A_DRF  = {28'h0, tdo_pkg::ADDR_DRIFT};
  localparam int          MARGIN = 300;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ma, mb;
  logic        acq_start, acq_done, out_o, out_oe, sa, sb, sde;
  logic [31:0] haddr, hwdata, hrdata, seed, st;
  logic [1:0]  htrans, gain;
  logic [2:0]  hsize;
  logic [13:0] acq_result, level;
  logic [3:0]  dly;
  logic [15:0] hb_cnt;
  int          err_total, comparisons, cyc, lowcnt, gap, last_gap;

  tdo_core #(.BURST_CYC(BURST), .CONFIRM_CYC(32'h14), .HEALTH_CYC(HEALTH),
    .PULSE_CYC(PULSE), .TONE_CYC(32'h3c), .TONE_HALF_CYC(32'h4),
    .TMO_SHORT_CYC(TMS), .TMO_LONG_CYC(TML)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gain_strap(gain),
    .mode_strap_a(ma), .mode_strap_b(mb), .acq_start(acq_start), .acq_done(acq_done),
    .acq_result(acq_result), .out_o(out_o), .out_oe(out_oe), .sense_terminal_a(sa),
    .sense_terminal_b(sb), .sense_drive_en(sde));

  tdo_conv_model conv_u (.hclk(hclk), .hresetn(hresetn), .acq_start(acq_start),
    .dly(dly), .level(level), .out_o(out_o), .out_oe(out_oe), .acq_done(acq_done),
    .acq_result(acq_result), .hb_cnt(hb_cnt));

  always #12.5 hclk = ~hclk;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_val(nm, {31'h0, exp}, {31'h0, got});
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [13:0] thr_of(input int m, input logic hyst);
    if (m == 0)
      return hyst ? tdo_pkg::HYST_HIGH : tdo_pkg::THR_HIGH;
    if (m == 1)
      return hyst ? tdo_pkg::HYST_MED : tdo_pkg::THR_MED;
    return hyst ? tdo_pkg::HYST_LOW : tdo_pkg::THR_LOW;
  endfunction

  // Single word transfer; the master waits on hready with no assumed latency.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic bursts(input int n);
    repeat (n)
    begin
      dly <= 4'(rnd() % 32'h8);
      do @(posedge hclk); while (acq_done !== 1'b1);
    end
    repeat (2) @(posedge hclk);
  endtask

  task automatic run_mode(input int m);
    logic [13:0] r, thr, hy;
    logic [31:0] rd, dv;
    logic [15:0] hb0;
    int          tmo, t0;
    r = 14'(32'h400 + rnd() % 32'h1000);
    thr = thr_of(m, 1'b0);
    hy = thr_of(m, 1'b1);
    tmo = (m == 1) ? int'(TML) : int'(TMS);
    dv = {16'h0, 8'(8 + m), 8'(1 + m)};
    level <= r;
    hresetn <= 1'b0;
    ma <= (m < 2);
    mb <= (m == 0 || m == 3);
    gain <= 2'(m);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bursts(1);
    ahb(1'b0, A_REF, 32'h0, rd);
    chk_val("ref_cal", {18'h0, r}, rd);
    ma <= ~ma;
    mb <= ~mb;
    gain <= ~gain;
    ahb(1'b0, A_DRF, 32'h0, rd);
    chk_val("drift_rst", {16'h0, tdo_pkg::DRIFT_FALL_RST, tdo_pkg::DRIFT_RISE_RST}, rd);
    ahb(1'b1, A_DRF, dv, rd);
    ahb(1'b0, A_DRF, 32'h0, rd);
    chk_val("drift", dv, rd);
    ahb(1'b0, 32'h2, 32'h0, rd);
    chk_val("unmapped", 32'h0, rd);
    chk_bit("hresp", 1'b0, hresp);
    level <= r + 14'h8;
    bursts(1);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_val("mode", 32'(m), 32'(st[tdo_pkg::ST_MODE_LSB +: 2]));
    chk_val("gain", 32'(m), 32'(st[tdo_pkg::ST_GAIN_LSB +: 2]));
    chk_bit("slow_gap", 1'b1, last_gap >= int'(BURST));
    ahb(1'b0, A_SIG, 32'h0, rd);
    chk_val("signal", {18'h0, r + 14'h8}, rd);
    ahb(1'b0, A_REF, 32'h0, rd);
    chk_val("ref_up", 32'(r + 14'(1 + m)), rd);
    level <= r - 14'h40;
    bursts(1);
    ahb(1'b0, A_REF, 32'h0, rd);
    chk_val("ref_down", 32'(r - 14'h7), rd);
    r = r - 14'h7;
    level <= r;
    bursts(1);
    level <= r + thr;
    bursts(2);
    chk_bit("confirm_gap", 1'b1, last_gap < int'(BURST));
    ahb(1'b0, A_ST, 32'h0, st);
    chk_val("integ2", 32'h2, 32'(st[tdo_pkg::ST_INTEG_LSB +: 3]));
    level <= r;
    bursts(1);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_val("integ_clr", 32'h0, 32'(st[tdo_pkg::ST_INTEG_LSB +: 3]));
    level <= r + thr;
    hb0 = hb_cnt;
    bursts(3);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_bit("det3", 1'b0, st[tdo_pkg::ST_DETECT_BIT]);
    bursts(1);
    chk_val("health_seen", 32'h4, 32'(hb_cnt - hb0));
    ahb(1'b0, A_ST, 32'h0, st);
    t0 = cyc;
    chk_bit("det4", 1'b1, st[tdo_pkg::ST_DETECT_BIT]);
    chk_bit("st_out", 1'b1, st[tdo_pkg::ST_OUT_BIT]);
    chk_bit("st_tone", m != 3, st[tdo_pkg::ST_TONE_BIT]);
    chk_bit("out_on", 1'b1, out_o);
    chk_bit("tone", m != 3, sde);
    chk_bit("antiphase", m != 3, sa ^ sb);
    repeat (int'(PULSE)) @(posedge hclk);
    chk_bit("out_hold", m != 3, out_o);
    level <= r + thr + 14'h1e;
    bursts(2);
    ahb(1'b0, A_REF, 32'h0, rd);
    chk_val("ref_frozen", {18'h0, r}, rd);
    repeat (tmo - MARGIN - (cyc - t0)) @(posedge hclk);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_bit("det_pre_tmo", 1'b1, st[tdo_pkg::ST_DETECT_BIT]);
    repeat (2 * MARGIN) @(posedge hclk);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_bit("det_tmo", 1'b0, st[tdo_pkg::ST_DETECT_BIT]);
    chk_bit("out_tmo", m == 2, out_o);
    bursts(2);
    r = r + thr + 14'h1e;
    ahb(1'b0, A_REF, 32'h0, rd);
    chk_val("ref_recal", {18'h0, r}, rd);
    level <= r + thr;
    bursts(4);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_bit("det_again", 1'b1, st[tdo_pkg::ST_DETECT_BIT]);
    chk_bit("out_again", m != 2, out_o);
    level <= r + thr - hy;
    bursts(1);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_bit("det_hyst", 1'b1, st[tdo_pkg::ST_DETECT_BIT]);
    level <= r + thr - hy - 14'h1;
    bursts(1);
    ahb(1'b0, A_ST, 32'h0, st);
    chk_bit("det_rel", 1'b0, st[tdo_pkg::ST_DETECT_BIT]);
    chk_bit("out_off", 1'b0, out_o);
  endtask

  // Health window length is measured at every burst start, in every mode.
  always @(posedge hclk)
  begin
    cyc++;
    if (hresetn !== 1'b1)
    begin
      lowcnt = 0;
      gap = 0;
    end
    else if (acq_start === 1'b1)
    begin
      chk_val("health_len", HEALTH, 32'(lowcnt));
      last_gap = gap;
      lowcnt = 0;
      gap = 1;
    end
    else
    begin
      gap++;
      if (out_oe === 1'b0)
        lowcnt++;
    end
  end

  always @(posedge hclk)
  begin
    if (cyc == 80000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ma = 1'b1;
    mb = 1'b1;
    gain = 2'h0;
    level = 14'h800;
    dly = 4'h2;
    seed = 32'h4b;
    err_total = 0;
    comparisons = 0;
    cyc = 0;
    last_gap = 0;
    repeat (2) @(posedge hclk);
    chk_bit("rst_oe", 1'b1, out_oe);
    chk_bit("rst_out", 1'b0, out_o);
    chk_bit("rst_start", 1'b0, acq_start);
    for (int m = 0; m < 4; m++)
      run_mode(m);
    close_out();
  end
endmodule
